// >>> hrep_host.sv
/*
 * Host processor model for the register emulation port: runs one read or
 * write cycle per call and resolves the shared data lines.
 * Assumes the caller invokes cyc only from a process synchronous to clk_i.
 */
`timescale 1ns/1ps
module hrep_host (
    input wire logic clk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_n_i,
    output logic [7:0] bus_o,
    output logic [2:0] addr_o,
    output logic fm_sel_n_o,
    output logic midi_sel_n_o,
    output logic wr_n_o,
    output logic rd_n_o
);
    logic drv_q = 1'b0;
    logic [7:0] wd_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    // No pull-up: a floating bus flips each clock between the old byte and its complement
    assign bus_o = !dev_oe_n_i ? dev_data_i : drv_q ? wd_q : ~last_q;
    always @(posedge clk_i) last_q <= bus_o;
    initial begin
        addr_o = 3'h0;
        fm_sel_n_o = 1'b1;
        midi_sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
    end
    // Strobe low 9 clocks, data held 6 clocks past the strobe
    task automatic cyc(input logic wr, input logic [1:0] sel_n, input logic [2:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic on, output logic off);
        @(posedge clk_i);
        addr_o <= a;
        fm_sel_n_o <= sel_n[0];
        midi_sel_n_o <= sel_n[1];
        wd_q <= d;
        drv_q <= wr;
        wr_n_o <= !wr;
        rd_n_o <= wr;
        repeat (8) @(posedge clk_i);
        #1;
        q = bus_o;
        on = dev_oe_n_i;
        @(posedge clk_i);
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
        off = dev_oe_n_i;
        @(posedge clk_i);
        drv_q <= 1'b0;
        fm_sel_n_o <= 1'b1;
        midi_sel_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// >>> hrep_port.sv
/*
 * Host register emulation port: two emulated register sets of eight bytes
 * each (FM-synth set and UART-mode MIDI set) reached over a parallel host bus,
 * two interrupt outputs, and sticky power-down.
 * Assumes the synth core updates host-readable bytes through the core port
 * and consumes the host write and read pulses; host pins are asynchronous.
 */
// How it works
// RULE1: The eight host data lines carry bytes both ways between host and device.
// RULE2: A low FM chip select steers the access to the FM register set.
// RULE3: A low MIDI chip select steers the access to the MIDI UART register set.
// RULE4: The three address lines pick one of eight bytes in the selected set.
// RULE5: A low write strobe stores the host data byte in the addressed register.
// RULE6: A low read strobe puts the addressed register on the host data lines.
// RULE7: The active-low FM interrupt follows the FM set's request for attention.
// RULE8: The active-high MIDI interrupt follows the MIDI set's request for attention.
// RULE9: Reset puts every register and state of the port to its starting value.
// RULE10: The host board holds reset low at power-on until the oscillator settles.
// RULE11: While reset is low the port is idle: no drive, no interrupts.
// RULE12: A low power-down input sends the port into its low-power state.
// RULE13: Power-down is left only through reset, not by releasing the input.
// RULE14: Data lines are driven only while read strobe and a chip select are low.
`timescale 1ns/1ps
module hrep_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [hrep_pkg::DATA_W-1:0] host_data_i,
    output logic [hrep_pkg::DATA_W-1:0] host_data_o,
    output logic host_data_oe_n_o,
    input wire logic [hrep_pkg::ADDR_W-1:0] host_addr_i,
    input wire logic fm_reg_select_n_i,
    input wire logic midi_uart_select_n_i,
    input wire logic host_write_n_i,
    input wire logic host_read_n_i,
    input wire logic power_down_n_i,
    output logic fm_irq_n_o,
    output logic midi_irq_o,
    output logic low_power_o,
    input wire logic core_wr_i,
    input wire logic [hrep_pkg::IDX_W-1:0] core_idx_i,
    input wire logic [hrep_pkg::DATA_W-1:0] core_wdata_i,
    input wire logic fm_irq_req_i,
    input wire logic midi_irq_req_i,
    output logic host_wr_stb_o,
    output logic [hrep_pkg::IDX_W-1:0] host_wr_idx_o,
    output logic [hrep_pkg::DATA_W-1:0] host_wr_data_o,
    output logic host_rd_stb_o,
    output logic [hrep_pkg::IDX_W-1:0] host_rd_idx_o
);
    typedef struct packed {
        hrep_pkg::hrep_state_t state;
        logic [hrep_pkg::NREG-1:0][hrep_pkg::DATA_W-1:0] regs;
        logic [hrep_pkg::DATA_W-1:0] rdata;
        logic rd_en;
        logic wr_prev;
        logic rd_prev;
        logic wr_prev2;
        logic rd_prev2;
        logic fm_irq;
        logic midi_irq;
        logic wr_stb;
        logic [hrep_pkg::IDX_W-1:0] wr_idx;
        logic [hrep_pkg::DATA_W-1:0] wr_data;
        logic rd_stb;
        logic [hrep_pkg::IDX_W-1:0] rd_idx;
    } hrep_port_st_t;

    function automatic logic [hrep_pkg::IDX_W-1:0] reg_idx(
        input logic set,
        input logic [hrep_pkg::ADDR_W-1:0] addr
    );
        reg_idx = {set, addr};
    endfunction

    logic [hrep_pkg::SYNC_W-1:0] pins;
    logic [hrep_pkg::SYNC_W-1:0] syn;
    logic [hrep_pkg::DATA_W-1:0] data_s;
    logic [hrep_pkg::ADDR_W-1:0] addr_s;
    logic sel_fm;
    logic sel_midi;
    logic sel_any;
    logic rd_act;
    logic wr_act;
    logic pd_act;
    logic [hrep_pkg::IDX_W-1:0] idx;
    logic write_fire;
    logic read_fire;
    logic running;
    hrep_port_st_t q;
    hrep_port_st_t d;

    assign pins = {power_down_n_i, host_write_n_i, host_read_n_i, midi_uart_select_n_i,
                   fm_reg_select_n_i, host_addr_i, host_data_i};

    hrep_sync #(
        .W(hrep_pkg::SYNC_W),
        .RST(hrep_pkg::SYNC_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(pins),
        .val_o(syn)
    );

    assign data_s = syn[hrep_pkg::SB_DATA_LO +: hrep_pkg::DATA_W]; // RULE1
    assign addr_s = syn[hrep_pkg::SB_ADDR_LO +: hrep_pkg::ADDR_W];
    // Both selects low at once is a host fault; the FM set takes it
    assign sel_fm = !syn[hrep_pkg::SB_CS_FM]; // RULE2
    assign sel_midi = !syn[hrep_pkg::SB_CS_MIDI] && syn[hrep_pkg::SB_CS_FM]; // RULE3
    assign sel_any = sel_fm || sel_midi;
    assign rd_act = !syn[hrep_pkg::SB_RD];
    assign wr_act = !syn[hrep_pkg::SB_WR];
    assign pd_act = !syn[hrep_pkg::SB_PD];
    assign idx = reg_idx(sel_fm ? hrep_pkg::SET_FM : hrep_pkg::SET_MIDI, addr_s); // RULE4
    assign running = (q.state == hrep_pkg::HREP_RUN);
    // Act on the second synchronised cycle of a strobe: data, address and select bits that
    // crossed one clock later than the strobe have settled by then
    assign write_fire = running && !pd_act && sel_any
                        && wr_act && q.wr_prev && !q.wr_prev2; // RULE5
    assign read_fire = running && !pd_act && sel_any
                       && rd_act && q.rd_prev && !q.rd_prev2;

    always_comb begin
        d = q;
        d.wr_prev = wr_act;
        d.rd_prev = rd_act;
        d.wr_prev2 = q.wr_prev;
        d.rd_prev2 = q.rd_prev;
        d.wr_stb = 1'b0;
        d.rd_stb = 1'b0;
        unique case (q.state)
            hrep_pkg::HREP_RUN: begin
                if (pd_act) begin
                    d.state = hrep_pkg::HREP_PDOWN; // RULE12
                    d.rd_en = 1'b0;
                    d.fm_irq = 1'b0;
                    d.midi_irq = 1'b0;
                end else begin
                    // Core update first so a host write to the same byte wins
                    if (core_wr_i) begin
                        d.regs[core_idx_i] = core_wdata_i;
                    end
                    if (write_fire) begin
                        d.regs[idx] = data_s; // RULE5
                        d.wr_stb = 1'b1;
                        d.wr_idx = idx;
                        d.wr_data = data_s;
                    end
                    d.rd_en = rd_act && sel_any; // RULE14
                    if (rd_act && sel_any) begin
                        d.rdata = q.regs[idx]; // RULE6
                    end
                    if (read_fire) begin
                        d.rd_stb = 1'b1;
                        d.rd_idx = idx;
                    end
                    d.fm_irq = fm_irq_req_i; // RULE7
                    d.midi_irq = midi_irq_req_i; // RULE8
                end
            end
            hrep_pkg::HREP_PDOWN: begin
                // Only reset leaves this state; the pin going high does nothing
                d.rd_en = 1'b0; // RULE13
                d.fm_irq = 1'b0;
                d.midi_irq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.state <= hrep_pkg::HREP_RUN; // RULE9
            q.regs <= {hrep_pkg::NREG{hrep_pkg::REG_RST}};
            q.rdata <= hrep_pkg::REG_RST;
            q.rd_en <= 1'b0; // RULE11
            q.wr_prev <= 1'b0;
            q.rd_prev <= 1'b0;
            q.wr_prev2 <= 1'b0;
            q.rd_prev2 <= 1'b0;
            q.fm_irq <= 1'b0;
            q.midi_irq <= 1'b0;
            q.wr_stb <= 1'b0;
            q.wr_idx <= '0;
            q.wr_data <= hrep_pkg::REG_RST;
            q.rd_stb <= 1'b0;
            q.rd_idx <= '0;
        end else begin
            q <= d;
        end
    end

    assign host_data_o = q.rdata;
    assign host_data_oe_n_o = !q.rd_en; // RULE14
    assign fm_irq_n_o = !q.fm_irq;
    assign midi_irq_o = q.midi_irq;
    assign low_power_o = (q.state == hrep_pkg::HREP_PDOWN);
    assign host_wr_stb_o = q.wr_stb;
    assign host_wr_idx_o = q.wr_idx;
    assign host_wr_data_o = q.wr_data;
    assign host_rd_stb_o = q.rd_stb;
    assign host_rd_idx_o = q.rd_idx;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_write_edge;
        write_fire && !(core_wr_i && core_idx_i == idx);
    endsequence

    sequence s_pd_entry;
        running && pd_act;
    endsequence

    // A strobe first seen low, then still low with a select one cycle later
    sequence s_wr_settled;
        wr_act && !q.wr_prev ##1 running && !pd_act && wr_act && sel_any;
    endsequence

    sequence s_rd_settled;
        rd_act && !q.rd_prev ##1 running && !pd_act && rd_act && sel_any;
    endsequence

    a_write_store_byte: assert property ( // RULE5
        s_write_edge |=> q.regs[$past(idx)] == $past(data_s) && host_wr_stb_o
    ) else $error("host write byte not stored");

    a_write_pulse_once: assert property ( // RULE5
        host_wr_stb_o |=> !host_wr_stb_o
    ) else $error("write pulse longer than one cycle");

    a_read_data_out: assert property ( // RULE6
        running && !pd_act && rd_act && sel_any |=> !host_data_oe_n_o
            && host_data_o == $past(q.regs[idx])
    ) else $error("read data not presented");

    a_drive_only_read: assert property ( // RULE14
        !host_data_oe_n_o |-> $past(rd_act && sel_any && running)
    ) else $error("data lines driven outside a read");

    a_pd_entry_state: assert property ( // RULE12
        s_pd_entry |=> low_power_o ##1 low_power_o
    ) else $error("power-down not entered");

    a_pd_sticky_quiet: assert property ( // RULE13
        low_power_o |=> low_power_o && host_data_oe_n_o && fm_irq_n_o && !midi_irq_o
    ) else $error("power-down left or port not quiet");

    a_fm_irq_follow: assert property ( // RULE7
        running && !pd_act |=> fm_irq_n_o == !$past(fm_irq_req_i)
    ) else $error("fm interrupt does not follow request");

    a_midi_irq_follow: assert property ( // RULE8
        running && !pd_act |=> midi_irq_o == $past(midi_irq_req_i)
    ) else $error("midi interrupt does not follow request");

    a_write_fires: assert property ( // RULE5
        s_wr_settled |=> host_wr_stb_o
    ) else $error("settled host write gave no pulse");

    a_write_idx_data: assert property ( // RULE4
        host_wr_stb_o |-> host_wr_idx_o == $past(idx)
            && host_wr_data_o == $past(data_s)
    ) else $error("write index or byte not passed on");

    a_read_pulse_idx: assert property ( // RULE6
        s_rd_settled |=> host_rd_stb_o
            && host_rd_idx_o == $past(idx)
    ) else $error("settled host read gave no pulse");

    a_read_pulse_once: assert property ( // RULE6
        host_rd_stb_o |=> !host_rd_stb_o
    ) else $error("read pulse longer than one cycle");

    a_fm_set_index: assert property ( // RULE2
        write_fire && !syn[hrep_pkg::SB_CS_FM]
            |=> host_wr_idx_o[hrep_pkg::ADDR_W] == hrep_pkg::SET_FM
    ) else $error("fm select did not steer to the fm set");

    a_midi_set_index: assert property ( // RULE3
        write_fire && syn[hrep_pkg::SB_CS_FM]
            |=> host_wr_idx_o[hrep_pkg::ADDR_W] == hrep_pkg::SET_MIDI
    ) else $error("midi select did not steer to the midi set");

    a_strobe_has_select: assert property ( // RULE2
        host_wr_stb_o || host_rd_stb_o
            |-> $past(sel_any && running && !pd_act)
    ) else $error("access taken without a chip select");

    a_pd_no_access: assert property ( // RULE13
        low_power_o |=> !host_wr_stb_o && !host_rd_stb_o
    ) else $error("host access taken in power-down");

    a_pd_regs_kept: assert property ( // RULE12
        low_power_o |=> $stable(q.regs)
    ) else $error("registers changed in power-down");

    a_read_release: assert property ( // RULE14
        !(rd_act && sel_any) |=> host_data_oe_n_o
    ) else $error("data lines still driven after the read");

    a_core_write_lands: assert property ( // RULE6
        running && !pd_act && core_wr_i && !(write_fire && idx == core_idx_i)
            |=> q.regs[$past(core_idx_i)] == $past(core_wdata_i)
    ) else $error("core byte not stored");
endmodule

// >>> hrep_port_tb.sv
/*
 * Self-checking bench for hrep_port: host cycles through hrep_host, core
 * writes and interrupt requests, power-down and a mid-run reset.
 * Assumes hrep_pkg and the design modules are compiled first.
 */
`timescale 1ns/1ps
module hrep_port_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pd_n = 1'b1;
    logic core_wr = 1'b0;
    logic [3:0] core_idx = 4'h0;
    logic [7:0] core_wd = 8'h00;
    logic fm_req = 1'b0;
    logic midi_req = 1'b0;
    logic [7:0] bus, data_o, wr_data, q, rnd;
    logic [3:0] wr_idx, rd_idx;
    logic [2:0] addr;
    logic oe_n, fm_irq_n, midi_irq, low_pwr, wr_stb, rd_stb, fm_n, midi_n, wr_n, rd_n, on, off;
    int err_count = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_rd = 0;
    int mdl [16];
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (wr_stb === 1'b1) n_wr <= n_wr + 1;
        if (rd_stb === 1'b1) n_rd <= n_rd + 1;
    end
    hrep_host hrep_host_inst (.clk_i(clk_i), .dev_data_i(data_o), .dev_oe_n_i(oe_n),
        .bus_o(bus), .addr_o(addr), .fm_sel_n_o(fm_n), .midi_sel_n_o(midi_n),
        .wr_n_o(wr_n), .rd_n_o(rd_n));
    hrep_port hrep_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_data_i(bus),
        .host_data_o(data_o), .host_data_oe_n_o(oe_n), .host_addr_i(addr),
        .fm_reg_select_n_i(fm_n), .midi_uart_select_n_i(midi_n), .host_write_n_i(wr_n),
        .host_read_n_i(rd_n), .power_down_n_i(pd_n), .fm_irq_n_o(fm_irq_n),
        .midi_irq_o(midi_irq), .low_power_o(low_pwr), .core_wr_i(core_wr),
        .core_idx_i(core_idx), .core_wdata_i(core_wd), .fm_irq_req_i(fm_req),
        .midi_irq_req_i(midi_req), .host_wr_stb_o(wr_stb), .host_wr_idx_o(wr_idx),
        .host_wr_data_o(wr_data), .host_rd_stb_o(rd_stb), .host_rd_idx_o(rd_idx));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [1:0] sel_n, input int i, input int d);
        hrep_host_inst.cyc(wr, sel_n, i[2:0], d[7:0], q, on, off);
    endtask
    initial begin
        #100000;
        err_count++;
        conclude;
    end
    initial begin
        rnd = 8'h33;
        for (int i = 0; i < 16; i++) mdl[i] = 0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk({oe_n, fm_irq_n, midi_irq, low_pwr}, 8'h0C);
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            acc(1'b1, i[3] ? 2'b01 : 2'b10, i, rnd);
            mdl[i] = rnd;
            chk(wr_data, rnd);
            chk(8'(wr_idx), 8'(i));
        end
        acc(1'b1, 2'b11, 2, 8'hA5);
        acc(1'b1, 2'b00, 3, ~mdl[3]);
        mdl[3] = 8'(~mdl[3]);
        chk(8'(n_wr), 8'h11);
        for (int i = 0; i < 17; i++) begin
            acc(1'b0, i == 16 ? 2'b11 : i[3] ? 2'b01 : 2'b10, i, 0);
            chk(on, 8'(i == 16));
            chk(off, 8'h01);
            if (i < 16) begin
                chk(q, 8'(mdl[i]));
                chk(8'(rd_idx), 8'(i));
            end
        end
        chk(8'(n_rd), 8'h10);
        rnd = lfsr(rnd);
        mdl[9] = rnd;
        core_wr <= 1'b1;
        core_idx <= 4'h9;
        core_wd <= rnd;
        fm_req <= 1'b1;
        midi_req <= 1'b1;
        @(posedge clk_i);
        core_wr <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({fm_irq_n, midi_irq}, 8'h01);
        acc(1'b0, 2'b01, 1, 0);
        chk(q, 8'(mdl[9]));
        pd_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        pd_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        chk({low_pwr, fm_irq_n, midi_irq}, 8'h06);
        acc(1'b0, 2'b10, 0, 0);
        chk(on, 8'h01);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk({oe_n, low_pwr, fm_irq_n, midi_irq}, 8'h0A);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        fm_req <= 1'b0;
        midi_req <= 1'b0;
        repeat (5) @(posedge clk_i);
        acc(1'b0, 2'b01, 1, 0);
        chk(q, 8'h00);
        chk({low_pwr, fm_irq_n, midi_irq}, 8'h02);
        conclude;
    end
endmodule

// >>> hrep_sync.sv
/*
 * Package of shared constants for the host register emulation port, and the
 * three-stage input synchroniser used on every host pin.
 * Assumes host pins are asynchronous to clk_i and that the host holds its
 * strobes for several clock periods, as an ISA-style cycle does.
 */
package hrep_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int IDX_W = ADDR_W + 1;
    localparam int NREG = 16;
    localparam int SYNC_W = 16;
    // Bit positions of the host pins inside the synchronised bundle
    localparam int SB_DATA_LO = 0;
    localparam int SB_ADDR_LO = 8;
    localparam int SB_CS_FM = 11;
    localparam int SB_CS_MIDI = 12;
    localparam int SB_RD = 13;
    localparam int SB_WR = 14;
    localparam int SB_PD = 15;
    // Idle level of the bundle: all active-low pins high, data and address low
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 16'hF800;
    localparam logic SET_FM = 1'b0;
    localparam logic SET_MIDI = 1'b1;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;

    typedef enum logic [1:0] {
        HREP_RUN = 2'b01,
        HREP_PDOWN = 2'b10
    } hrep_state_t;
endpackage

`timescale 1ns/1ps
module hrep_sync #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] val_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } hrep_sync_st_t;

    hrep_sync_st_t q;
    hrep_sync_st_t d;

    // Stage one feeds stage two only; a bit is accepted once stages two and three agree
    always_comb begin
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.val = (q.s2 & ~(q.s2 ^ q.s3)) | (q.val & (q.s2 ^ q.s3));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= {RST, RST, RST, RST};
        end else begin
            q <= d;
        end
    end

    assign val_o = q.val;
endmodule
